// *** include/gtrr_regs.svh ***
// Constants of the gate timing readback register bank.
// Assumes a 5-bit register address and 16-bit register words.
`ifndef GTRR_REGS_SVH
`define GTRR_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define GTRR_ADDR_PWM1_SWITCH_DELAY 5'h14
`define GTRR_ADDR_PWM2_SWITCH_DELAY 5'h15
`define GTRR_ADDR_PWM3_SWITCH_DELAY 5'h16
`define GTRR_ADDR_PWM1_EDGE_TIMES   5'h17
`define GTRR_ADDR_PWM2_EDGE_TIMES   5'h18
`define GTRR_ADDR_PWM3_EDGE_TIMES   5'h19
`define GTRR_ADDR_PART_IDENTIFIER   5'h1f

// ****************************************
// Field positions
// ****************************************
`define GTRR_HI_MSB 15
`define GTRR_HI_LSB 8
`define GTRR_LO_MSB 7
`define GTRR_LO_LSB 0
`define GTRR_ID_ONE_BIT 7

// ****************************************
// Reset values and timing
// ****************************************
`define GTRR_TIMING_RESET 16'h0000
`define GTRR_ID_TOP_BYTE  8'h00
`define GTRR_STEP_PS      62500

`endif

// *** include/gtrr_pkg.sv ***
// Types of the gate timing readback register bank.
// Assumes the constants header is on the include path.
package gtrr_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [4:0]  gtrr_addr_t;
  typedef logic [15:0] gtrr_word_t;
  typedef logic [7:0]  gtrr_count_t;

  // Slots 0..2 hold the switch delays, slots 3..5 the edge times
  typedef struct packed {
    logic [5:0][15:0] slot;
    logic [15:0]      rdata;
    logic             rvalid;
    logic             wign;
  } gtrr_state_s;

endpackage

// *** rtl/gtrr_bank.sv ***
// Read-only bank of measured gate switching times for three PWM channels.
// Assumes the measurement logic and the serial frame decoder run on I_CLK_SYS.
//
// Behaviour
// - Turn-off delay count in delay bits 15:8
// - Turn-on delay count in delay bits 7:0
// - Fall time count in edge bits 15:8
// - Rise time count in edge bits 7:0
// - Delay registers at 0x14..0x16, reset zero
// - Edge registers at 0x17..0x19, reset zero
// - Identifier bit 7 always reads one
// - Identifier bits 15:8 always read zero
`timescale 1ns/1ps
`include "gtrr_regs.svh"

module gtrr_bank #(
  parameter logic [2:0] DEV_ID   = 3'h2,  // Arbitrary value
  parameter logic [3:0] ID_RSVD  = 4'h0   // Arbitrary value
) (
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_NRST,
  input  wire gtrr_pkg::gtrr_addr_t  I_ADDR,
  input  wire logic                  I_RD_EN,
  input  wire logic                  I_WR_EN,
  input  wire gtrr_pkg::gtrr_word_t  I_WDATA,
  input  wire logic [2:0]            I_DLY_UPD,
  input  wire logic [2:0]            I_EDGE_UPD,
  input  wire gtrr_pkg::gtrr_count_t I_CH1_OFF_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH1_ON_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH2_OFF_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH2_ON_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH3_OFF_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH3_ON_DELAY,
  input  wire gtrr_pkg::gtrr_count_t I_CH1_FALL_TIME,
  input  wire gtrr_pkg::gtrr_count_t I_CH1_RISE_TIME,
  input  wire gtrr_pkg::gtrr_count_t I_CH2_FALL_TIME,
  input  wire gtrr_pkg::gtrr_count_t I_CH2_RISE_TIME,
  input  wire gtrr_pkg::gtrr_count_t I_CH3_FALL_TIME,
  input  wire gtrr_pkg::gtrr_count_t I_CH3_RISE_TIME,
  output logic [15:0]                O_RDATA,
  output logic                       O_RD_VALID,
  output logic                       O_WR_IGNORED
);
  import gtrr_pkg::*;

  // ****************************************
  // Read decode
  // ****************************************
  // Unmapped addresses read as zero so the frame decoder never sees stale data
  function automatic gtrr_word_t read_word(input gtrr_addr_t a,
                                           input logic [5:0][15:0] s);
    gtrr_word_t w;
    w = 16'h0000;
    if (a == `GTRR_ADDR_PWM1_SWITCH_DELAY) w = s[0];
    else if (a == `GTRR_ADDR_PWM2_SWITCH_DELAY) w = s[1];
    else if (a == `GTRR_ADDR_PWM3_SWITCH_DELAY) w = s[2];
    else if (a == `GTRR_ADDR_PWM1_EDGE_TIMES) w = s[3];
    else if (a == `GTRR_ADDR_PWM2_EDGE_TIMES) w = s[4];
    else if (a == `GTRR_ADDR_PWM3_EDGE_TIMES) w = s[5];
    else if (a == `GTRR_ADDR_PART_IDENTIFIER)
      w = {`GTRR_ID_TOP_BYTE, 1'b1, ID_RSVD, DEV_ID};
    return w;
  endfunction

  // ****************************************
  // State
  // ****************************************
  gtrr_state_s state;
  gtrr_state_s next_state;
  gtrr_count_t hi_in [6];
  gtrr_count_t lo_in [6];
  logic [5:0]  upd;

  // ****************************************
  // Measurement capture
  // ****************************************
  assign upd = {I_EDGE_UPD, I_DLY_UPD};

  always_comb
  begin
    hi_in[0] = I_CH1_OFF_DELAY;
    lo_in[0] = I_CH1_ON_DELAY;
    hi_in[1] = I_CH2_OFF_DELAY;
    lo_in[1] = I_CH2_ON_DELAY;
    hi_in[2] = I_CH3_OFF_DELAY;
    lo_in[2] = I_CH3_ON_DELAY;
    hi_in[3] = I_CH1_FALL_TIME;
    lo_in[3] = I_CH1_RISE_TIME;
    hi_in[4] = I_CH2_FALL_TIME;
    lo_in[4] = I_CH2_RISE_TIME;
    hi_in[5] = I_CH3_FALL_TIME;
    lo_in[5] = I_CH3_RISE_TIME;
  end

  always_comb
  begin
    next_state = state;
    for (int i = 0; i < 6; i++)
    begin
      if (upd[i])
      begin
        next_state.slot[i][`GTRR_HI_MSB:`GTRR_HI_LSB] = hi_in[i];
        next_state.slot[i][`GTRR_LO_MSB:`GTRR_LO_LSB] = lo_in[i];
      end
    end
    // Read returns the value held before any same-cycle update
    next_state.rvalid = I_RD_EN;
    next_state.rdata  = I_RD_EN ? read_word(I_ADDR, state.slot) : state.rdata;
    // Write data is dropped; only the pulse tells the decoder it hit read-only space
    next_state.wign   = I_WR_EN;
    if (!I_NRST)
    begin
      next_state        = '0;
      next_state.slot   = {6{`GTRR_TIMING_RESET}};
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge I_CLK_SYS)
  begin
    state <= next_state;
  end

  assign O_RDATA      = state.rdata;
  assign O_RD_VALID   = state.rvalid;
  assign O_WR_IGNORED = state.wign;

  // ****************************************
  // Assertions
  // ****************************************
  property p_off_delay;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[0] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM1_SWITCH_DELAY && !I_DLY_UPD[0])
    |=> O_RDATA[15:8] == $past(I_CH1_OFF_DELAY, 2);
  endproperty
  a_off_delay: assert property (p_off_delay) else $error("turn-off delay misplaced");

  property p_on_delay;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[1] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM2_SWITCH_DELAY && !I_DLY_UPD[1])
    |=> O_RDATA[7:0] == $past(I_CH2_ON_DELAY, 2) && O_RD_VALID;
  endproperty
  a_on_delay: assert property (p_on_delay) else $error("turn-on delay misplaced");

  property p_fall_time;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[2] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM3_EDGE_TIMES && !I_EDGE_UPD[2])
    |=> O_RDATA[15:8] == $past(I_CH3_FALL_TIME, 2);
  endproperty
  a_fall_time: assert property (p_fall_time) else $error("fall time misplaced");

  property p_rise_time;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[0] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM1_EDGE_TIMES && !I_EDGE_UPD[0])
    |=> O_RDATA[7:0] == $past(I_CH1_RISE_TIME, 2);
  endproperty
  a_rise_time: assert property (p_rise_time) else $error("rise time misplaced");

  property p_dly_reset;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    $rose(I_NRST) && I_RD_EN && I_ADDR == `GTRR_ADDR_PWM3_SWITCH_DELAY
    |=> O_RDATA == 16'h0000 && O_RD_VALID;
  endproperty
  a_dly_reset: assert property (p_dly_reset) else $error("delay not zero after reset");

  property p_edge_reset;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    $rose(I_NRST) && I_RD_EN && I_ADDR == `GTRR_ADDR_PWM2_EDGE_TIMES
    |=> O_RDATA == 16'h0000;
  endproperty
  a_edge_reset: assert property (p_edge_reset) else $error("edge time not zero after reset");

  property p_id_one;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_RD_EN && I_ADDR == `GTRR_ADDR_PART_IDENTIFIER |=> O_RDATA[7] == 1'b1;
  endproperty
  a_id_one: assert property (p_id_one) else $error("identifier bit 7 not one");

  property p_id_zero;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_RD_EN && I_ADDR == `GTRR_ADDR_PART_IDENTIFIER |=> O_RDATA[15:8] == 8'h00;
  endproperty
  a_id_zero: assert property (p_id_zero) else $error("identifier top byte not zero");

  property p_wr_ignored;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_WR_EN && upd == 6'h00 |=> state.slot == $past(state.slot) && O_WR_IGNORED;
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write altered the bank");

  property p_off_delay2;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[1] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM2_SWITCH_DELAY && !I_DLY_UPD[1])
    |=> O_RDATA[15:8] == $past(I_CH2_OFF_DELAY, 2);
  endproperty
  a_off_delay2: assert property (p_off_delay2) else $error("off delay 2 misplaced");

  property p_off_delay3;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[2] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM3_SWITCH_DELAY && !I_DLY_UPD[2])
    |=> O_RDATA[15:8] == $past(I_CH3_OFF_DELAY, 2);
  endproperty
  a_off_delay3: assert property (p_off_delay3) else $error("off delay 3 misplaced");

  property p_on_delay1;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[0] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM1_SWITCH_DELAY && !I_DLY_UPD[0])
    |=> O_RDATA[7:0] == $past(I_CH1_ON_DELAY, 2);
  endproperty
  a_on_delay1: assert property (p_on_delay1) else $error("on delay 1 misplaced");

  property p_on_delay3;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_DLY_UPD[2] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM3_SWITCH_DELAY && !I_DLY_UPD[2])
    |=> O_RDATA[7:0] == $past(I_CH3_ON_DELAY, 2);
  endproperty
  a_on_delay3: assert property (p_on_delay3) else $error("on delay 3 misplaced");

  property p_fall_time1;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[0] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM1_EDGE_TIMES && !I_EDGE_UPD[0])
    |=> O_RDATA[15:8] == $past(I_CH1_FALL_TIME, 2);
  endproperty
  a_fall_time1: assert property (p_fall_time1) else $error("fall time 1 misplaced");

  property p_fall_time2;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[1] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM2_EDGE_TIMES && !I_EDGE_UPD[1])
    |=> O_RDATA[15:8] == $past(I_CH2_FALL_TIME, 2);
  endproperty
  a_fall_time2: assert property (p_fall_time2) else $error("fall time 2 misplaced");

  property p_rise_time2;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[1] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM2_EDGE_TIMES && !I_EDGE_UPD[1])
    |=> O_RDATA[7:0] == $past(I_CH2_RISE_TIME, 2);
  endproperty
  a_rise_time2: assert property (p_rise_time2) else $error("rise time 2 misplaced");

  property p_rise_time3;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_EDGE_UPD[2] ##1 (I_RD_EN && I_ADDR == `GTRR_ADDR_PWM3_EDGE_TIMES && !I_EDGE_UPD[2])
    |=> O_RDATA[7:0] == $past(I_CH3_RISE_TIME, 2);
  endproperty
  a_rise_time3: assert property (p_rise_time3) else $error("rise time 3 misplaced");

  property p_dly_zero;
    @(posedge I_CLK_SYS)
    !I_NRST
    |=> state.slot[2:0] == {3{`GTRR_TIMING_RESET}};
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("delay slot not cleared");

  property p_edge_zero;
    @(posedge I_CLK_SYS)
    !I_NRST
    |=> state.slot[5:3] == {3{`GTRR_TIMING_RESET}};
  endproperty
  a_edge_zero: assert property (p_edge_zero) else $error("edge slot not cleared");

  property p_slot_hold;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    upd == 6'h00
    |=> state.slot == $past(state.slot);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot moved without update");

  property p_wr_readback;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_WR_EN && !I_RD_EN
    |=> O_RDATA == $past(O_RDATA) && O_WR_IGNORED;
  endproperty
  a_wr_readback: assert property (p_wr_readback) else $error("write moved read data");

  property p_wr_pulse;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    !I_WR_EN
    |=> !O_WR_IGNORED;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("stray write pulse");

  property p_rd_valid;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_RD_EN
    |=> O_RD_VALID;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

  property p_rd_idle;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    !I_RD_EN
    |=> !O_RD_VALID && O_RDATA == $past(O_RDATA);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read moved");

  property p_id_low;
    @(posedge I_CLK_SYS) disable iff (!I_NRST)
    I_RD_EN && I_ADDR == `GTRR_ADDR_PART_IDENTIFIER
    |=> O_RDATA[6:0] == {ID_RSVD, DEV_ID};
  endproperty
  a_id_low: assert property (p_id_low) else $error("identifier low bits wrong");

endmodule

// *** sim/gtrr_host.sv ***
// Serial master model reaching the bank through its register port.
// Assumes each task is entered just after a rising edge of i_clk.
`timescale 1ns/1ps
module gtrr_host (
  input  wire logic                 i_clk,
  input  wire gtrr_pkg::gtrr_word_t i_rdata,
  input  wire logic                 i_rd_valid,
  input  wire logic                 i_wr_ignored,
  output gtrr_pkg::gtrr_addr_t      o_addr,
  output logic                      o_rd_en,
  output logic                      o_wr_en,
  output gtrr_pkg::gtrr_word_t      o_wdata
);
  import gtrr_pkg::*;
  initial {o_addr, o_rd_en, o_wr_en, o_wdata} = '0;
  // The released address shows the inverse and the enables drop, so a stale value never passes
  task automatic xfer(input logic wr, input gtrr_addr_t a, output gtrr_word_t d,
                      output logic ack);
    o_addr = a;
    o_wdata = ~o_wdata;
    o_rd_en = !wr;
    o_wr_en = wr;
    @(posedge i_clk);
    #1;
    d = i_rdata;
    ack = wr ? i_wr_ignored : i_rd_valid;
    o_rd_en = 1'b0;
    o_wr_en = 1'b0;
    o_addr = ~a;
    @(posedge i_clk);
    #1;
  endtask
endmodule

// *** sim/test_gate_timing_readback_regs.sv ***
// Self-checking bench of the gate timing readback bank.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
module test_gate_timing_readback_regs;
  import gtrr_pkg::*;
  logic        clk;
  logic        nrst;
  logic [2:0]  dly_upd;
  logic [2:0]  edge_upd;
  gtrr_count_t c [12];
  gtrr_word_t  exp_w [6];
  gtrr_word_t  rdata, d, wdata;
  gtrr_addr_t  addr;
  logic        rd_en, wr_en, rd_valid, wr_ign, ack;
  int          fail_count = 0;
  int          cmp_count = 0;
  gtrr_bank DUT (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_RD_EN(rd_en),
    .I_WR_EN(wr_en), .I_WDATA(wdata), .I_DLY_UPD(dly_upd), .I_EDGE_UPD(edge_upd),
    .I_CH1_OFF_DELAY(c[0]), .I_CH1_ON_DELAY(c[1]), .I_CH2_OFF_DELAY(c[2]),
    .I_CH2_ON_DELAY(c[3]), .I_CH3_OFF_DELAY(c[4]), .I_CH3_ON_DELAY(c[5]),
    .I_CH1_FALL_TIME(c[6]), .I_CH1_RISE_TIME(c[7]), .I_CH2_FALL_TIME(c[8]),
    .I_CH2_RISE_TIME(c[9]), .I_CH3_FALL_TIME(c[10]), .I_CH3_RISE_TIME(c[11]),
    .O_RDATA(rdata), .O_RD_VALID(rd_valid), .O_WR_IGNORED(wr_ign));
  gtrr_host host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .i_wr_ignored(wr_ign), .o_addr(addr), .o_rd_en(rd_en), .o_wr_en(wr_en),
    .o_wdata(wdata));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    for (int j = 0; j < 6; j++)
    begin
      host.xfer(1'b0, 5'h14 + 5'((j + 2) % 6), d, ack);
      chk("reset slot", d, 16'h0000);
      chk("read valid", {15'h0, ack}, 16'h0001);
    end
    host.xfer(1'b0, 5'h00, d, ack);
    chk("unmapped", d, 16'h0000);
  endtask
  // Reset after a load, first read in the first cycle after release
  task automatic t_mid_reset();
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("rdata in reset", rdata, 16'h0000);
    chk("strobes in reset", {14'h0, rd_valid, wr_ign}, 16'h0000);
    nrst = 1'b1;
    for (int j = 0; j < 6; j++)
    begin
      host.xfer(1'b0, 5'h14 + 5'((j + 4) % 6), d, ack);
      chk("slot after reset", d, 16'h0000);
    end
  endtask
  task automatic t_ident();
    host.xfer(1'b0, 5'h1f, d, ack);
    chk("id top byte", {8'h00, d[15:8]}, 16'h0000);
    chk("id bit 7", {15'h0, d[7]}, 16'h0001);
  endtask
  // Inputs change after the load, so a slot that follows them is caught
  task automatic t_load();
    for (int k = 0; k < 12; k++) c[k] = 8'h5a + 8'(k * 37);
    for (int j = 0; j < 6; j++) exp_w[j] = {c[2*j], c[2*j+1]};
    dly_upd = 3'h7;
    edge_upd = 3'h7;
    @(posedge clk);
    #1;
    dly_upd = 3'h0;
    edge_upd = 3'h0;
    for (int k = 0; k < 12; k++) c[k] = ~c[k];
    for (int j = 0; j < 6; j++)
    begin
      host.xfer(1'b0, 5'h14 + 5'(j), d, ack);
      chk("high byte", {8'h00, d[15:8]}, {8'h00, exp_w[j][15:8]});
      chk("low byte", {8'h00, d[7:0]}, {8'h00, exp_w[j][7:0]});
    end
    // One slot at a time, read in the very next cycle
    for (int j = 0; j < 6; j++)
    begin
      c[2*j] = 8'hc3 ^ 8'(j);
      c[2*j+1] = 8'h3c ^ 8'(j);
      exp_w[j] = {c[2*j], c[2*j+1]};
      {edge_upd, dly_upd} = 6'h01 << j;
      @(posedge clk);
      #1;
      {edge_upd, dly_upd} = 6'h00;
      host.xfer(1'b0, 5'h14 + 5'(j), d, ack);
      chk("next cycle read", d, exp_w[j]);
    end
  endtask
  task automatic t_write();
    for (int j = 0; j < 7; j++)
    begin
      host.xfer(1'b1, (j == 6) ? 5'h1f : 5'h14 + 5'(j), d, ack);
      chk("write ignored", {15'h0, ack}, 16'h0001);
    end
    for (int j = 0; j < 6; j++)
    begin
      host.xfer(1'b0, 5'h14 + 5'(j), d, ack);
      chk("after write", d, exp_w[j]);
    end
    t_ident();
  endtask
  initial
  begin
    nrst = 1'b0;
    dly_upd = 3'h0;
    edge_upd = 3'h0;
    for (int k = 0; k < 12; k++) c[k] = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_ident();
    t_load();
    t_write();
    t_mid_reset();
    give_verdict();
  end
  initial
  begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
